// ==== rtl/asf_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the flag block
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

`define ASF_OFS_OP 8'h00
`define ASF_OFS_FLAGS 8'h04
`define ASF_OFS_WORK 8'h08
`define ASF_OFS_FILE 8'h0C
`define ASF_OFS_RESULT 8'h10

`define ASF_FLAGS_FILE_ADDR 8'h04

`define ASF_BIT_C 0
`define ASF_BIT_DC 1
`define ASF_BIT_Z 2
`define ASF_BIT_OV 3
`define ASF_PTR_A_LO 4
`define ASF_PTR_B_LO 6

`define ASF_OP_CODE_LO 0
`define ASF_OP_DEST_FILE 4
`define ASF_OP_USE_LIT 5
`define ASF_OP_SRC_W 6
`define ASF_OP_ADDR_LO 8
`define ASF_OP_LIT_LO 16

`define ASF_FLAGS_RST 8'hF0
`define ASF_WORK_RST 8'h00
`define ASF_FILE_RST 8'h00
`define ASF_OP_RST 32'h0000_0000

`define ASF_ANSWER_CYCLES 1

`endif

// ==== rtl/asf_pkg.sv ====
// Types shared by the flag block and its arithmetic unit
package asf_pkg;
  typedef enum logic [3:0] {
    ASF_ADD, ASF_ADDC, ASF_SUB, ASF_SUBB, ASF_AND, ASF_IOR, ASF_XOR, ASF_CLR,
    ASF_COM, ASF_INC, ASF_DEC, ASF_MOV, ASF_SWAP, ASF_BCLR, ASF_BSET, ASF_MOVW
  } asf_op_e;
endpackage

// ==== rtl/asf_alu_if.sv ====
// Connection between the flag block and its arithmetic unit
`timescale 1ns/1ps
interface asf_alu_if;
  asf_pkg::asf_op_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic [2:0] bit_sel;
  logic cin;
  logic [7:0] res;
  logic [3:0] flg;
  logic [3:0] aff;
  modport ctl (output op, a, b, bit_sel, cin, input res, flg, aff);
  modport alu (input op, a, b, bit_sel, cin, output res, flg, aff);
endinterface

// ==== rtl/asf_alu.sv ====
// Combinational arithmetic unit producing result and the four result flags
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_alu (
  asf_alu_if.alu p
);
  // Packs {ov, dc, c, sum}; carry out doubles as not-borrow when y is inverted
  function automatic logic [10:0] arith(input logic [7:0] x, input logic [7:0] y,
                                        input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    logic ov;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    ov = (x[7] == y[7]) && (s[7] != x[7]);
    return {ov, n[4], s[8], s[7:0]};
  endfunction

  logic [10:0] t;
  logic [7:0] mask;

  always_comb begin
    t = {3'b000, p.b};
    mask = 8'h01 << p.bit_sel;
    p.aff = 4'b0100;
    case (p.op)
      asf_pkg::ASF_ADD: t = arith(p.b, p.a, 1'b0);
      asf_pkg::ASF_ADDC: t = arith(p.b, p.a, p.cin);
      asf_pkg::ASF_SUB: t = arith(p.b, ~p.a, 1'b1);
      asf_pkg::ASF_SUBB: t = arith(p.b, ~p.a, p.cin);
      asf_pkg::ASF_INC: t = arith(p.b, 8'h00, 1'b1);
      asf_pkg::ASF_DEC: t = arith(p.b, 8'hFF, 1'b0);
      asf_pkg::ASF_AND: t = {3'b000, p.b & p.a};
      asf_pkg::ASF_IOR: t = {3'b000, p.b | p.a};
      asf_pkg::ASF_XOR: t = {3'b000, p.b ^ p.a};
      asf_pkg::ASF_CLR: t = 11'h000;
      asf_pkg::ASF_COM: t = {3'b000, ~p.b};
      asf_pkg::ASF_MOV: t = {3'b000, p.b};
      asf_pkg::ASF_SWAP: t = {3'b000, p.b[3:0], p.b[7:4]};
      asf_pkg::ASF_BCLR: t = {3'b000, p.b & ~mask};
      asf_pkg::ASF_BSET: t = {3'b000, p.b | mask};
      asf_pkg::ASF_MOVW: t = {3'b000, p.a};
      default: t = {3'b000, p.b};
    endcase
    case (p.op)
      asf_pkg::ASF_ADD, asf_pkg::ASF_ADDC, asf_pkg::ASF_SUB, asf_pkg::ASF_SUBB,
      asf_pkg::ASF_INC, asf_pkg::ASF_DEC: p.aff = 4'b1111;
      asf_pkg::ASF_SWAP, asf_pkg::ASF_BCLR, asf_pkg::ASF_BSET,
      asf_pkg::ASF_MOVW: p.aff = 4'b0000;
      default: p.aff = 4'b0100;
    endcase
    p.res = t[7:0];
    p.flg[`ASF_BIT_C] = t[8];
    p.flg[`ASF_BIT_DC] = t[9];
    p.flg[`ASF_BIT_Z] = (t[7:0] == 8'h00);
    p.flg[`ASF_BIT_OV] = t[10];
  end
endmodule

// ==== rtl/alu_status_flags.sv ====
// ALU flag register block with operand select and Avalon-MM register access
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "asf_cfg.svh"
module alu_status_flags (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [7:0] flags_o,
  output logic ptr_a_inc_o,
  output logic ptr_a_dec_o,
  output logic ptr_b_inc_o,
  output logic ptr_b_dec_o
);
  asf_alu_if alu_bus ();

  asf_alu u_alu (
    .p(alu_bus.alu)
  );

  logic [7:0] flags;
  logic [7:0] work;
  logic [7:0] file_reg;
  logic [31:0] op_reg;
  logic [7:0] result;
  logic [31:0] rdata;
  logic busy;
  logic [3:0] ptr_step;

  logic [7:0] next_flags;
  logic [7:0] next_work;
  logic [7:0] next_file_reg;
  logic [31:0] next_op_reg;
  logic [7:0] next_result;
  logic [31:0] next_rdata;
  logic next_busy;
  logic [3:0] next_ptr_step;

  logic req;
  logic accept;
  logic op_wr;
  logic [31:0] op_word;
  logic [7:0] fa;
  logic [7:0] file_val;
  logic to_flags;
  logic [7:0] f_upd;
  logic [7:0] f_dest;

  // Byte-lane merge shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Pair code 00 decrements, 01 increments, 1x holds; returns {inc, dec}
  function automatic logic [1:0] step(input logic [1:0] mode);
    return mode[1] ? 2'b00 : (mode[0] ? 2'b10 : 2'b01);
  endfunction

  function automatic logic is_two(input asf_pkg::asf_op_e op);
    case (op)
      asf_pkg::ASF_ADD, asf_pkg::ASF_ADDC, asf_pkg::ASF_SUB, asf_pkg::ASF_SUBB,
      asf_pkg::ASF_AND, asf_pkg::ASF_IOR, asf_pkg::ASF_XOR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] adr, input logic [7:0] fl,
                                           input logic [7:0] wk, input logic [7:0] fr,
                                           input logic [31:0] opw, input logic [7:0] rs);
    case (adr)
      `ASF_OFS_OP: return opw;
      `ASF_OFS_FLAGS: return {24'h00_0000, fl};
      `ASF_OFS_WORK: return {24'h00_0000, wk};
      `ASF_OFS_FILE: return {24'h00_0000, fr};
      `ASF_OFS_RESULT: return {24'h00_0000, rs};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // One wait cycle per access keeps read data registered
  assign req = avs_read_i | avs_write_i;
  assign accept = req & busy;
  assign avs_waitrequest_o = req & ~(busy & ce_i);
  assign op_wr = avs_write_i & accept & (avs_address_i == `ASF_OFS_OP);

  // The operation word in flight is the merged write so it runs at the accepting edge
  assign op_word = op_wr ? merge(op_reg, avs_writedata_i, avs_byteenable_i) : op_reg;
  assign fa = op_word[`ASF_OP_ADDR_LO +: 8];
  assign to_flags = (fa == `ASF_FLAGS_FILE_ADDR);
  // No bank decode here: address 04h reaches the flag register in every bank
  assign file_val = to_flags ? flags : file_reg;

  always_comb begin
    alu_bus.op = asf_pkg::asf_op_e'(op_word[`ASF_OP_CODE_LO +: 4]);
    alu_bus.a = work;
    alu_bus.bit_sel = op_word[`ASF_OP_LIT_LO +: 3];
    alu_bus.cin = flags[`ASF_BIT_C];
    if (is_two(asf_pkg::asf_op_e'(op_word[`ASF_OP_CODE_LO +: 4]))) begin
      alu_bus.b = op_word[`ASF_OP_USE_LIT] ? op_word[`ASF_OP_LIT_LO +: 8] : file_val;
    end else begin
      alu_bus.b = op_word[`ASF_OP_SRC_W] ? work : file_val;
    end
  end

  // Flags after the operation, before any destination write lands on them
  always_comb begin
    f_upd = flags;
    for (int i = 0; i < 4; i++) begin
      if (alu_bus.aff[i]) begin
        f_upd[i] = alu_bus.flg[i];
      end
    end
  end

  // Destination write to the flag register itself
  always_comb begin
    f_dest = alu_bus.res;
    if (alu_bus.aff[2:0] != 3'b000) begin
      f_dest[`ASF_BIT_Z:`ASF_BIT_C] = f_upd[`ASF_BIT_Z:`ASF_BIT_C];
      if (alu_bus.aff[`ASF_BIT_OV]) begin
        f_dest[`ASF_BIT_OV] = f_upd[`ASF_BIT_OV];
      end else if (alu_bus.op == asf_pkg::ASF_CLR) begin
        f_dest[`ASF_BIT_OV] = flags[`ASF_BIT_OV];
      end
    end
  end

  always_comb begin
    next_flags = flags;
    next_work = work;
    next_file_reg = file_reg;
    next_op_reg = op_reg;
    next_result = result;
    next_rdata = rdata;
    next_busy = req & ~busy;
    if (req && !busy) begin
      next_rdata = read_mux(avs_address_i, flags, work, file_reg, op_reg, result);
    end
    if (avs_write_i && accept) begin
      case (avs_address_i)
        `ASF_OFS_OP: next_op_reg = op_word;
        `ASF_OFS_FLAGS: next_flags = 8'(merge({24'h00_0000, flags}, avs_writedata_i,
                                              avs_byteenable_i));
        `ASF_OFS_WORK: next_work = 8'(merge({24'h00_0000, work}, avs_writedata_i,
                                            avs_byteenable_i));
        `ASF_OFS_FILE: next_file_reg = 8'(merge({24'h00_0000, file_reg}, avs_writedata_i,
                                                avs_byteenable_i));
        default: next_op_reg = op_reg;
      endcase
    end
    // An operation runs only when its code byte is written
    if (op_wr && avs_byteenable_i[0]) begin
      next_result = alu_bus.res;
      next_flags = f_upd;
      if (!op_word[`ASF_OP_DEST_FILE]) begin
        next_work = alu_bus.res;
      end else if (to_flags) begin
        next_flags = f_dest;
      end else begin
        next_file_reg = alu_bus.res;
      end
    end
    next_ptr_step = {step(next_flags[`ASF_PTR_B_LO +: 2]),
                     step(next_flags[`ASF_PTR_A_LO +: 2])};
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flags <= `ASF_FLAGS_RST;
      work <= `ASF_WORK_RST;
      file_reg <= `ASF_FILE_RST;
      op_reg <= `ASF_OP_RST;
      result <= 8'h00;
      rdata <= 32'h0000_0000;
      busy <= 1'b0;
      ptr_step <= 4'h0;
    end else if (ce_i) begin
      flags <= next_flags;
      work <= next_work;
      file_reg <= next_file_reg;
      op_reg <= next_op_reg;
      result <= next_result;
      rdata <= next_rdata;
      busy <= next_busy;
      ptr_step <= next_ptr_step;
    end
  end

  assign avs_readdata_o = rdata;
  assign flags_o = flags;
  assign ptr_a_dec_o = ptr_step[0];
  assign ptr_a_inc_o = ptr_step[1];
  assign ptr_b_dec_o = ptr_step[2];
  assign ptr_b_inc_o = ptr_step[3];
endmodule

// ==== test/asf_asserts.sv ====
// Port assertions for the flag block
`timescale 1ns/1ps
module asf_asserts (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [7:0] flags_o,
  input wire logic ptr_a_inc_o,
  input wire logic ptr_a_dec_o,
  input wire logic ptr_b_inc_o,
  input wire logic ptr_b_dec_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire logic acc = ce_i && !avs_waitrequest_o;
  reset_val_a: assert property (disable iff (1'b0)
    $fell(reset_i) |-> flags_o == 8'hF0) else $error("flags not at reset value");
  ptr_a_mode_a: assert property (
    ptr_a_inc_o == (flags_o[5:4] == 2'b01) && ptr_a_dec_o == (flags_o[5:4] == 2'b00))
    else $error("pointer A step wrong");
  ptr_b_mode_a: assert property (
    ptr_b_inc_o == (flags_o[7:6] == 2'b01) && ptr_b_dec_o == (flags_o[7:6] == 2'b00))
    else $error("pointer B step wrong");
  one_wait_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i ##1 ce_i |-> !avs_waitrequest_o)
    else $error("bus answer late");
  ce_hold_a: assert property (
    (avs_read_i || avs_write_i) && !ce_i |-> avs_waitrequest_o) else $error("answer while frozen");
  direct_wr_a: assert property (
    avs_write_i && acc && avs_address_i == 8'h04 && avs_byteenable_i[0]
    |=> {24'h0, flags_o} == ($past(avs_writedata_i) & 32'h0000_00FF)) else $error("flag write lost");
  clr_flag_a: assert property (
    avs_write_i && acc && avs_address_i == 8'h00 && avs_byteenable_i == 4'hF
    && avs_writedata_i[15:0] == 16'h0417 |=> flags_o[7:4] == 4'h0 && flags_o[2]
    && (flags_o & 8'h0B) == ($past(flags_o) & 8'h0B)) else $error("clear of flags wrong");
  rd_flags_a: assert property (
    avs_read_i && acc && avs_address_i == 8'h04 |-> avs_readdata_o == {24'h0, flags_o})
    else $error("flag read wrong");
endmodule
bind alu_status_flags asf_asserts chk (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .flags_o(flags_o),
  .ptr_a_inc_o(ptr_a_inc_o), .ptr_a_dec_o(ptr_a_dec_o), .ptr_b_inc_o(ptr_b_inc_o),
  .ptr_b_dec_o(ptr_b_dec_o));

// ==== test/alu_status_flags_tb.sv ====
// Self-checking random bench for the flag block
`timescale 1ns/1ps
module alu_status_flags_tb;
  logic mclk_i = 0, reset_i = 1, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [7:0] avs_address_i = 8'h00, flags_o, w, f, r, e, l;
  logic [2:0] sel;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF, c, be_sel = 4'hF;
  logic avs_waitrequest_o, ptr_a_inc_o, ptr_a_dec_o, ptr_b_inc_o, ptr_b_dec_o;
  logic [11:0] x;
  logic [7:0] wc[3] = '{8'h7F, 8'h01, 8'hFF};
  logic [7:0] fc[3] = '{8'h01, 8'h80, 8'h00};
  int n_errors = 0, cmp_count = 0, i, t;
  wire logic [3:0] steps = {ptr_a_inc_o, ptr_a_dec_o, ptr_b_inc_o, ptr_b_dec_o};
  alu_status_flags dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .flags_o(flags_o),
    .ptr_a_inc_o(ptr_a_inc_o), .ptr_a_dec_o(ptr_a_dec_o), .ptr_b_inc_o(ptr_b_inc_o),
    .ptr_b_dec_o(ptr_b_dec_o));
  always #12.5 mclk_i = ~mclk_i;
  // Random stalls stretch some accesses, so no task may assume a fixed wait
  always @(posedge mclk_i) ce_i <= ($urandom % 4) != 0;
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be_sel;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    k = 0;
    // Waitrequest is sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 60);
    if (avs_waitrequest_o !== 1'b0) begin
      n_errors++;
      end_sim();
    end else begin
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(negedge mclk_i);
    end
  endtask
  // Returns overflow, zero, nibble and carry flags above the result, from starting flags fl
  function automatic logic [11:0] model(input logic [3:0] op, input logic [7:0] a, b, l,
                                        input logic [3:0] fl);
    logic [7:0] s, v;
    logic [8:0] y;
    logic [4:0] h;
    logic ci;
    logic [3:0] nf;
    s = (op == 4'h9) ? 8'h00 : (op == 4'hA) ? 8'hFF : (op == 4'h2 || op == 4'h3) ? ~a : a;
    ci = (op == 4'h2 || op == 4'h9) ? 1'b1 : (op == 4'h1 || op == 4'h3) ? fl[0] : 1'b0;
    y = b + s + ci;
    h = b[3:0] + s[3:0] + ci;
    case (op)
      4'h4: v = b & a;
      4'h5: v = b | a;
      4'h6: v = b ^ a;
      4'h7: v = 8'h00;
      4'h8: v = ~b;
      4'hB: v = b;
      4'hC: v = {b[3:0], b[7:4]};
      4'hD: v = b & ~(8'h01 << l[2:0]);
      4'hE: v = b | (8'h01 << l[2:0]);
      4'hF: v = a;
      default: v = y[7:0];
    endcase
    nf = fl;
    if (op <= 4'hB) begin
      nf[2] = (v == 8'h00);
    end
    if (op <= 4'h3 || op == 4'h9 || op == 4'hA) begin
      nf = {(b[7] == s[7]) && (y[7] != b[7]), v == 8'h00, h[4], y[8]};
    end
    return {nf, v};
  endfunction
  initial begin
    void'($urandom(69816));
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    bus(0, 8'h04, 32'h0);
    chk("flags reset", q, 32'h0000_00F0);
    chk("steps reset", steps, 32'h0);
    bus(0, 8'h20, 32'h0);
    chk("unmapped read", q, 32'h0);
    $display("reset test done");
    for (i = 0; i < 16; i++) begin
      bus(1, 8'h04, {i[3:0], 4'h5});
      chk("mode flags", flags_o, {i[3:0], 4'h5});
      chk("steps", steps, {i[1:0] == 2'd1, i[1:0] == 2'd0, i[3:2] == 2'd1, i[3:2] == 2'd0});
    end
    be_sel = 4'hE;
    bus(1, 8'h04, 32'h0000_0000);
    be_sel = 4'hF;
    chk("lane off", flags_o, 8'hF5);
    $display("mode test done");
    for (i = 0; i < 60; i++) begin
      c = (i < 3) ? ((i == 2) ? 4'h9 : 4'(i * 2)) : 4'($urandom);
      w = (i < 3) ? wc[i] : 8'($urandom);
      f = (i < 3) ? fc[i] : 8'($urandom);
      l = (i < 3) ? f : 8'($urandom);
      r = 8'($urandom);
      sel = (i < 3) ? 3'b100 : 3'($urandom);
      bus(1, 8'h08, w);
      bus(1, 8'h0C, f);
      bus(1, 8'h04, r);
      bus(1, 8'h00, {8'h00, l, 8'h00, 1'b0, sel, c});
      e = (c <= 4'h6) ? (sel[1] ? l : f) : (sel[2] ? w : f);
      x = model(c, w, e, l, r[3:0]);
      bus(0, 8'h10, 32'h0);
      chk("result", q, x[7:0]);
      chk("flags", flags_o, {r[7:4], x[11:8]});
      bus(0, 8'h08, 32'h0);
      chk("work", q, sel[0] ? w : x[7:0]);
      bus(0, 8'h0C, 32'h0);
      chk("file", q, sel[0] ? x[7:0] : f);
    end
    $display("arith test done");
    for (i = 0; i < 30; i++) begin
      t = i % 4;
      r = 8'($urandom);
      w = 8'($urandom);
      f = 8'($urandom);
      c = (t == 0) ? 4'h0 : (t == 1) ? 4'h7 : (t == 2) ? 4'hC : 4'h8;
      bus(1, 8'h08, w);
      bus(1, 8'h04, r);
      bus(1, 8'h00, {8'h0, f, 8'h04, 2'b00, t == 0, 1'b1, c});
      x = model(4'h0, w, f, f, r[3:0]);
      e = t == 0 ? {x[7:4], x[11:8]} : t == 1 ? {4'h0, r[3], 1'b1, r[1:0]} :
          t == 2 ? {r[3:0], r[7:4]} : {~r[7:3], r == 8'hFF, r[1:0]};
      chk("flag dest", flags_o, e);
    end
    $display("flag dest test done");
    end_sim();
  end
endmodule
